// ===== logic/sicr_regs.v
// s-interface channel control, diagnostic and status register bank
//
// Operation
// - control sampled once per frame, last wins
// - loop 10 digital, 11 remote
// - loop 00 none, 01 near end
// - hold bit keeps lock when framing lost
// - otherwise lock after three clean framings
// - bit 4 inverts framing violation rule
// - bit 3 sends all ones
// - bit 2 forces echo bits zero
// - bit 1 selects slave timing
// - write bit 0 picks diagnostic or control
// - status bit 7 sync or bus activity
// - activity: three zeros in 48, 128 ones clear
// - status bits 6-5 link state code
// - status bit 4 received maintenance bit
// - status bits 3-0 read ones
// - status refreshed once per frame
// - activate, deactivate wins, zeros raise neither request
// - bit 5 moves d-channel to b1
// - bit 4 selects priority class
// - bit 3 requests d-channel
// - bit 2 sent in q-channel
// - bit 1 clears diagnostic register
`timescale 1ns/100ps
`include "sicr_defs.vh"
module sicr_regs
(
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control channel access
    input  wire       wr_en,
    input  wire [4:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    input  wire [4:0] rd_addr,
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    // backplane frame pulse, one cycle per frame
    input  wire       frame_pulse,
    // line receive events
    input  wire       rx_bit_valid,
    input  wire       rx_bit,
    input  wire       rx_framing_ok,
    input  wire       rx_framing_err,
    input  wire       half_select,
    input  wire       multiframe_on,
    input  wire       rx_fa_bit,
    input  wire [1:0] link_state_code,
    // applied diagnostic settings
    output reg  [1:0] loop_mode,
    output reg        near_loop,
    output reg        digital_loop,
    output reg        remote_loop,
    output reg        hold_frame_lock,
    output reg        framing_violation_invert,
    output reg        tx_all_ones,
    output reg        force_echo_zero,
    output reg        slave_mode,
    // applied control settings
    output reg        activate_request,
    output reg        deactivate_request,
    output reg        dchan_in_b1_slot,
    output reg        dchan_high_class,
    output reg        dchan_request,
    output reg        tx_maint_bit,
    output reg        clear_diagnostics,
    // line sync state
    output reg        frame_sync,
    output reg        bus_activity
);

    // staged values awaiting the next frame
    reg [7:0] diag_stage_r;
    reg [7:0] ctrl_stage_r;
    // applied values
    reg [7:0] diag_r;
    reg [7:0] ctrl_r;
    // status snapshot
    reg [7:0] status_r;
    // sync counter
    reg [1:0] sync_cnt_r;
    // bus activity window and counters
    reg [5:0] ba_win_r;
    reg [1:0] ba_zero_r;
    reg [7:0] ba_ones_r;
    // received maintenance bit latch
    reg       rx_maint_bit_r;
    // live status word
    reg [7:0] status_nxt;

    // write staging: any number of writes per frame, last kept
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            diag_stage_r <= `SICR_DIAG_RESET;
            ctrl_stage_r <= `SICR_CTRL_RESET;
        end
        else if (wr_en && wr_addr == `SICR_ADDR_CTRL)
        begin
            if (wr_data[`SICR_BANK_SELECT_BIT])
                diag_stage_r <= wr_data;
            else
                ctrl_stage_r <= wr_data;
        end
    end

    // frame sampling of staged values
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            diag_r <= `SICR_DIAG_RESET;
            ctrl_r <= `SICR_CTRL_RESET;
        end
        else if (frame_pulse)
        begin
            ctrl_r <= ctrl_stage_r;
            if (ctrl_stage_r[`SICR_CLEAR_DIAGNOSTICS_BIT])
                diag_r <= `SICR_DIAG_RESET;
            else
                diag_r <= diag_stage_r;
        end
    end

    // decode applied diagnostic word
    always @*
    begin
        loop_mode    = diag_r[`SICR_LOOP_HI:`SICR_LOOP_LO];
        near_loop    = (loop_mode == `SICR_LOOP_NEAR);
        digital_loop = (loop_mode == `SICR_LOOP_DIGITAL);
        remote_loop  = (loop_mode == `SICR_LOOP_REMOTE);
        hold_frame_lock          = diag_r[`SICR_HOLD_LOCK_BIT];
        framing_violation_invert = diag_r[`SICR_FLV_BIT];
        tx_all_ones              = diag_r[`SICR_IDLE_BIT];
        force_echo_zero          = diag_r[`SICR_ECHO_BIT];
        slave_mode               = diag_r[`SICR_SLAVE_BIT];
    end

    // decode applied control word
    always @*
    begin
        deactivate_request = ctrl_r[`SICR_DR_BIT];
        activate_request   = ctrl_r[`SICR_AR_BIT] & ~ctrl_r[`SICR_DR_BIT];
        dchan_in_b1_slot   = ctrl_r[`SICR_DCHAN_IN_B1_SLOT_BIT];
        dchan_high_class   = ctrl_r[`SICR_PRIO_BIT];
        dchan_request      = ctrl_r[`SICR_DCHAN_REQUEST_BIT];
        tx_maint_bit       = ctrl_r[`SICR_TXM_BIT];
        clear_diagnostics  = ctrl_r[`SICR_CLEAR_DIAGNOSTICS_BIT];
    end

    // frame sync tracking
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_cnt_r <= 2'h0;
            frame_sync <= 1'b0;
        end
        else if (rx_framing_err)
        begin
            sync_cnt_r <= 2'h0;
            if (!hold_frame_lock)
                frame_sync <= 1'b0;
        end
        else if (rx_framing_ok && !frame_sync)
        begin
            if (sync_cnt_r == `SICR_SYNC_FRAMES - 2'h1)
            begin
                frame_sync <= 1'b1;
                sync_cnt_r <= 2'h0;
            end
            else
                sync_cnt_r <= sync_cnt_r + 2'h1;
        end
    end

    // bus activity detection on received line bits
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ba_win_r     <= 6'h0;
            ba_zero_r    <= 2'h0;
            ba_ones_r    <= 8'h0;
            bus_activity <= 1'b0;
        end
        else if (rx_bit_valid)
        begin
            if (!rx_bit)
            begin
                ba_ones_r <= 8'h0;
                if (ba_zero_r == 2'h0)
                    ba_win_r <= 6'h1;
                else
                    ba_win_r <= ba_win_r + 6'h1;
                if (ba_zero_r == `SICR_BA_ZEROS - 2'h1)
                begin
                    bus_activity <= 1'b1;
                    ba_zero_r    <= 2'h0;
                end
                else
                    ba_zero_r <= ba_zero_r + 2'h1;
            end
            else
            begin
                // window expiry restarts zero count
                if (ba_zero_r != 2'h0)
                begin
                    if (ba_win_r >= `SICR_BA_WINDOW - 6'h1)
                        ba_zero_r <= 2'h0;
                    else
                        ba_win_r <= ba_win_r + 6'h1;
                end
                if (ba_ones_r == `SICR_BA_ONES - 8'h1)
                begin
                    bus_activity <= 1'b0;
                    ba_ones_r    <= 8'h0;
                end
                else
                    ba_ones_r <= ba_ones_r + 8'h1;
            end
        end
    end

    // received maintenance bit capture
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_maint_bit_r <= 1'b1;
        else if (!multiframe_on)
            rx_maint_bit_r <= 1'b1;
        else if (!half_select)
            rx_maint_bit_r <= rx_fa_bit;
    end

    // live status word assembly
    always @*
    begin
        status_nxt = 8'h00;
        status_nxt[7]   = activate_request ? frame_sync : bus_activity;
        status_nxt[6:5] = link_state_code;
        status_nxt[4]   = rx_maint_bit_r;
        status_nxt[3:0] = `SICR_STATUS_LOW;
    end

    // status snapshot and read path
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_r <= {4'h0, `SICR_STATUS_LOW};
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            if (frame_pulse)
                status_r <= status_nxt;
            rd_valid <= rd_en;
            // write-only and unmapped read as zero
            if (rd_en && rd_addr == `SICR_ADDR_STATUS)
                rd_data <= status_r;
            else if (rd_en)
                rd_data <= 8'h00;
        end
    end

endmodule // sicr_regs

// ===== logic/sicr_defs.vh
// constants for the s-interface channel register bank
`ifndef SICR_DEFS_VH
`define SICR_DEFS_VH
// register addresses on the control channel
`define SICR_ADDR_CTRL        5'h08
`define SICR_ADDR_STATUS      5'h09
// shared write word fields
`define SICR_BANK_SELECT_BIT  0
// diagnostic fields
`define SICR_LOOP_HI          7
`define SICR_LOOP_LO          6
`define SICR_HOLD_LOCK_BIT    5
`define SICR_FLV_BIT          4
`define SICR_IDLE_BIT         3
`define SICR_ECHO_BIT         2
`define SICR_SLAVE_BIT        1
// loopback codes
`define SICR_LOOP_NONE        2'h0
`define SICR_LOOP_NEAR        2'h1
`define SICR_LOOP_DIGITAL     2'h2
`define SICR_LOOP_REMOTE      2'h3
// control fields
`define SICR_AR_BIT           7
`define SICR_DR_BIT           6
`define SICR_DCHAN_IN_B1_SLOT_BIT         5
`define SICR_PRIO_BIT         4
`define SICR_DCHAN_REQUEST_BIT         3
`define SICR_TXM_BIT          2
`define SICR_CLEAR_DIAGNOSTICS_BIT       1
// reset values
`define SICR_DIAG_RESET       8'h00
`define SICR_CTRL_RESET       8'h02
// status low nibble reads ones
`define SICR_STATUS_LOW       4'hF
// framing and activity figures
`define SICR_SYNC_FRAMES      2'h3
`define SICR_BA_ZEROS         2'h3
`define SICR_BA_WINDOW        6'h30
`define SICR_BA_ONES          8'h80
`endif

// ===== verification/sicr_regs_chk.sv
// assertion checker for the channel register bank
`timescale 1ns/100ps
module sicr_chk
(
    // clock and reset
    input wire       clk,
    input wire       rst_n,
    // access and line events
    input wire       rd_en,
    input wire [4:0] rd_addr,
    input wire [7:0] rd_data,
    input wire       rd_valid,
    input wire       frame_pulse,
    input wire       rx_framing_ok,
    input wire       rx_framing_err,
    // applied settings
    input wire [1:0] loop_mode,
    input wire       digital_loop,
    input wire       remote_loop,
    input wire       hold_frame_lock,
    input wire       activate_request,
    input wire       deactivate_request,
    input wire       clear_diagnostics,
    input wire       frame_sync
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_loop_decode: assert property (
        digital_loop == (loop_mode == 2'h2) && remote_loop == (loop_mode == 2'h3))
        else $error("loop decode wrong");
    a_frame_only: assert property (
        !frame_pulse && !$past(frame_pulse) |=> $stable({loop_mode, hold_frame_lock,
        activate_request, deactivate_request, clear_diagnostics}))
        else $error("settings moved between frames");
    a_clear_diag: assert property (
        clear_diagnostics |-> loop_mode == 2'h0 && !hold_frame_lock)
        else $error("diagnostics not cleared");
    a_dr_wins: assert property (deactivate_request |-> !activate_request)
        else $error("activate beside deactivate");
    a_sync_lost: assert property (
        rx_framing_err && !hold_frame_lock |-> ##[1:2] !frame_sync)
        else $error("sync kept after framing error");
    a_sync_rise: assert property (
        $rose(frame_sync) |-> $past(rx_framing_ok) || $past(rx_framing_ok, 2))
        else $error("sync without good framing");
    a_rd_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    a_rd_ones: assert property (
        rd_en && rd_addr == 5'h09 |=> rd_data[3:0] == 4'hF)
        else $error("status low bits not ones");
    a_rd_unmapped: assert property (rd_en && rd_addr != 5'h09 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    c_frame: cover property (frame_pulse);
    c_status: cover property (rd_en && rd_addr == 5'h09);
    c_sync: cover property ($rose(frame_sync));
endmodule // sicr_chk
bind sicr_regs sicr_chk i_sicr_chk (.*);

// ===== verification/sicr_line_model.sv
// behavioural far-end line source for the register bank
`timescale 1ns/100ps
module sicr_line_model
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // pattern requests
    input wire send_zeros,
    input wire good_framing,
    input wire bad_framing,
    // received line events
    output reg rx_bit_valid,
    output reg rx_bit,
    output reg rx_framing_ok,
    output reg rx_framing_err
);
    reg [2:0] ph_r; // bit and framing phase
    // phase moves on the falling edge, like bench stimulus
    always @(negedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ph_r <= 3'h0;
        else
            ph_r <= ph_r + 3'h1;
    end
    // one bit every other cycle, framing every eighth; idle bit shows inverse
    always @*
    begin
        rx_bit_valid = ph_r[0];
        rx_bit = ph_r[0] ? ~send_zeros : send_zeros;
        rx_framing_ok = good_framing && ph_r == 3'h7;
        rx_framing_err = bad_framing && ph_r == 3'h7;
    end
endmodule // sicr_line_model

// ===== verification/testbench.sv
// self-checking bench for the channel register bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    logic       clk, rst_n, wr_en, rd_en, rd_valid, frame_pulse, half_select;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, sd, sc, er;
    logic [1:0] loop_mode, link_state_code, fd;
    logic       multiframe_on, rx_fa_bit, send_zeros, good_framing, bad_framing;
    logic       rx_bit_valid, rx_bit, rx_framing_ok, rx_framing_err, near_loop;
    logic       digital_loop, remote_loop, hold_frame_lock, framing_violation_invert;
    logic       tx_all_ones, force_echo_zero, slave_mode, activate_request;
    logic       deactivate_request, dchan_in_b1_slot, dchan_high_class, dchan_request;
    logic       tx_maint_bit, clear_diagnostics, frame_sync, bus_activity;
    logic [13:0] ec;
    logic [31:0] seed = 32'h4FE4E174; // xorshift state
    logic [7:0]  rq[$];               // expected read data
    logic [13:0] cq[$];               // expected applied settings
    int num_errors = 0;
    int total_checks = 0;
    sicr_regs i_sicr_regs (.*);
    sicr_line_model i_sicr_line_model (.*);
    always #4 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        // staged copies: bit 0 picks the bank
        if (a == 5'h08 && d[0]) sd = d;
        else if (a == 5'h08) sc = d;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        rq.push_back(e);
        @(negedge clk);
        rd_en = 1'b0;
    endtask
    // frame pulse; clear bit wipes the applied diagnostics
    task automatic frame();
        logic [7:0] d;
        d = sc[1] ? 8'h00 : sd;
        @(negedge clk);
        frame_pulse = 1'b1;
        cq.push_back({d[7:1], sc[7] & ~sc[6], sc[6:1]});
        @(negedge clk);
        frame_pulse = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // status snapshot, then changed inputs must not show in the same frame
    task automatic st(input logic b7);
        logic [7:0] e;
        seed = xs(seed);
        {link_state_code, multiframe_on, rx_fa_bit} = seed[3:0];
        half_select = 1'b0;
        e = {b7, link_state_code, multiframe_on ? rx_fa_bit : 1'b1, 4'hF};
        frame();
        rd(5'h09, e);
        {link_state_code, rx_fa_bit, half_select} = ~seed[4:1];
        rd(5'h09, e);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // monitor: read answers and the settings two cycles after each frame pulse
    always @(posedge clk) fd <= {fd[0], frame_pulse};
    always @(negedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            er = rq.pop_front();
            `CHK("read", er, rd_data)
        end
        if (fd[1] === 1'b1)
        begin
            ec = cq.pop_front();
            `CHK("applied", ec, {loop_mode, hold_frame_lock, framing_violation_invert, tx_all_ones,
                force_echo_zero, slave_mode, activate_request, deactivate_request,
                dchan_in_b1_slot, dchan_high_class, dchan_request, tx_maint_bit,
                clear_diagnostics})
            `CHK("loops", {ec[13:12] == 2'h1, ec[13:12] == 2'h2, ec[13:12] == 2'h3},
                {near_loop, digital_loop, remote_loop})
        end
    end
    // watchdog
    initial
    begin
        #200000;
        num_errors++;
        summarize();
    end
    initial
    begin
        {clk, rst_n, wr_en, rd_en, frame_pulse, wr_addr, wr_data, rd_addr, fd} = '0;
        {half_select, multiframe_on, rx_fa_bit, link_state_code} = '0;
        {send_zeros, good_framing, bad_framing} = '0;
        sd = 8'h00;
        sc = 8'h02;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(5'h09, 8'h0F);
        frame();
        rd(5'h08, 8'h00);
        // every loop code; decoy and foreign writes first, last wins
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            wr(5'h08, {seed[7:2], 2'h0});
            wr(5'h08, {seed[23:17], 1'b1});
            wr(5'h0A, 8'hFF);
            wr(5'h08, {k[1:0], seed[13:9], 1'b1});
            frame();
        end
        // held lock survives framing errors
        wr(5'h08, 8'h80);
        wr(5'h08, 8'h21);
        frame();
        good_framing = 1'b1;
        repeat (40) @(negedge clk);
        {good_framing, bad_framing} = 2'h1;
        repeat (40) @(negedge clk);
        st(1'b1);
        wr(5'h08, 8'h01);
        frame();
        repeat (20) @(negedge clk);
        st(1'b0);
        bad_framing = 1'b0;
        // bus activity while activation is off
        wr(5'h08, 8'h00);
        frame();
        send_zeros = 1'b1;
        repeat (20) @(negedge clk);
        st(1'b1);
        send_zeros = 1'b0;
        repeat (300) @(negedge clk);
        st(1'b0);
        wr(5'h08, 8'hFD);
        wr(5'h08, 8'h02);
        frame();
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule // testbench
